// File: oamd_decoder.v
// operand addressing mode decoder and effective address former
`include "oamd_regs.vh"

// How it works
// - memory relative: fetch pointer, add disp2
// - immediate destination flagged illegal
// - absolute uses displacement as address
// - external reads link entry, adds disp2
// - top of stack pushes on write, pops read
// - index scaled by one, two, four, eight
// - immediate or index base is illegal
// - implied immediate byte after all extensions
// - eight, sixteen, thirty-two bit displacements accepted
// - short operand is four bits in basic
// - condition is four bits in basic
// - codes zero to seven are registers
// - register relative is register plus displacement
// - index byte names register and base mode
// - extensions read most significant byte first
module oamd_decoder (
  input wire clk,
  input wire rst_b,
  input wire dec_valid,
  input wire [4:0] gen_mode,
  input wire [7:0] index_byte,
  input wire op_is_write,
  input wire [15:0] basic_bytes,
  input wire [63:0] ext_stream,
  input wire [255:0] gpr_flat,
  input wire [31:0] frame_pointer,
  input wire [31:0] static_base_pointer,
  input wire [31:0] interrupt_stack_pointer,
  input wire [31:0] user_stack_pointer,
  input wire stack_select,
  input wire [31:0] program_counter,
  input wire [31:0] link_table_base,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  output wire mem_req,
  output wire [31:0] mem_addr,
  output wire done,
  output wire [31:0] eff_addr,
  output wire is_register,
  output wire [2:0] reg_num,
  output wire is_immediate,
  output wire stack_push,
  output wire stack_pop,
  output wire illegal,
  output wire [6:0] ext_len,
  output wire [7:0] implied_imm,
  output wire [3:0] short_operand,
  output wire [3:0] cond_code
);
  // ----------------------------------------
  // state machine codes
  // ----------------------------------------
  localparam S_IDLE = 2'h0;
  localparam S_PTR = 2'h1;
  localparam S_DONE = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [31:0] disp2_q;
  reg [31:0] disp2_d;
  reg [31:0] idx_add_q;
  reg [31:0] idx_add_d;
  reg mem_req_q;
  reg mem_req_d;
  reg [31:0] mem_addr_q;
  reg [31:0] mem_addr_d;
  reg done_q;
  reg done_d;
  reg [31:0] eff_addr_q;
  reg [31:0] eff_addr_d;
  reg is_register_q;
  reg is_register_d;
  reg [2:0] reg_num_q;
  reg [2:0] reg_num_d;
  reg is_immediate_q;
  reg is_immediate_d;
  reg stack_push_q;
  reg stack_push_d;
  reg stack_pop_q;
  reg stack_pop_d;
  reg illegal_q;
  reg illegal_d;
  reg [6:0] ext_len_q;
  reg [6:0] ext_len_d;
  reg [7:0] implied_imm_q;
  reg [7:0] implied_imm_d;
  reg [3:0] short_operand_q;
  reg [3:0] short_operand_d;
  reg [3:0] cond_code_q;
  reg [3:0] cond_code_d;

  // ----------------------------------------
  // register file unpack
  // ----------------------------------------
  wire [31:0] gpr [0:7];
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_gpr
      assign gpr[gi] = gpr_flat[gi*32 +: 32];
    end
  endgenerate

  // ----------------------------------------
  // index byte and base mode
  // ----------------------------------------
  wire indexed = (gen_mode >= `OAMD_MODE_IDX_LO);
  wire [4:0] base_mode = indexed ? index_byte[7:3] : gen_mode;
  wire [2:0] idx_reg = index_byte[2:0];
  wire [1:0] scale = gen_mode[1:0];
  wire [31:0] idx_scaled = gpr[idx_reg] << scale;
  wire [31:0] cur_sp = stack_select ? user_stack_pointer : interrupt_stack_pointer;
  wire [63:0] ext_after_idx = indexed ? {ext_stream[55:0], 8'h00} : ext_stream;

  // ----------------------------------------
  // displacement extraction
  // ----------------------------------------
  wire [31:0] d1_val;
  wire [2:0] d1_len;
  wire d1_rsvd;
  wire [31:0] d2_val;
  wire [2:0] d2_len;
  wire d2_rsvd;

  oamd_disp_extract u_d1 (
    .ext_bytes(ext_after_idx[63:32]),
    .disp_value(d1_val),
    .disp_len(d1_len),
    .disp_reserved(d1_rsvd)
  );

  wire [63:0] ext_after_d1 = ext_after_idx << {d1_len, 3'h0};

  oamd_disp_extract u_d2 (
    .ext_bytes(ext_after_d1[63:32]),
    .disp_value(d2_val),
    .disp_len(d2_len),
    .disp_reserved(d2_rsvd)
  );

  // ----------------------------------------
  // mode classification
  // ----------------------------------------
  wire m_reg = (base_mode <= `OAMD_MODE_REG_HI);
  wire m_rrel = (base_mode >= `OAMD_MODE_RREL_LO) && (base_mode <= `OAMD_MODE_RREL_HI);
  wire m_mrel = (base_mode == `OAMD_MODE_MREL_FP) || (base_mode == `OAMD_MODE_MREL_SP) ||
                (base_mode == `OAMD_MODE_MREL_SB);
  wire m_imm = (base_mode == `OAMD_MODE_IMM);
  wire m_abs = (base_mode == `OAMD_MODE_ABS);
  wire m_ext = (base_mode == `OAMD_MODE_EXT);
  wire m_tos = (base_mode == `OAMD_MODE_TOS);
  wire m_msp = (base_mode >= `OAMD_MODE_MSP_FP) && (base_mode <= `OAMD_MODE_MSP_PC);
  wire two_disp = m_mrel || m_ext;
  wire one_disp = m_rrel || m_abs || m_msp;

  // an indexed base may not be immediate or indexed again
  wire bad_base = indexed && (m_imm || (base_mode >= `OAMD_MODE_IDX_LO));
  wire bad_imm = m_imm && op_is_write;
  wire bad_rsvd = ((one_disp || two_disp) && d1_rsvd) || (two_disp && d2_rsvd);
  wire bad_code = (base_mode == `OAMD_MODE_RSVD);
  wire bad_any = bad_base || bad_imm || bad_rsvd || bad_code;

  // ----------------------------------------
  // first base and extension length
  // ----------------------------------------
  reg [31:0] base_ptr;
  reg [6:0] len_sum;
  always @* begin
    base_ptr = 32'h00000000;
    case (base_mode)
      `OAMD_MODE_MREL_FP, `OAMD_MODE_MSP_FP: base_ptr = frame_pointer;
      `OAMD_MODE_MREL_SP, `OAMD_MODE_MSP_SP: base_ptr = cur_sp;
      `OAMD_MODE_MREL_SB, `OAMD_MODE_MSP_SB: base_ptr = static_base_pointer;
      `OAMD_MODE_MSP_PC: base_ptr = program_counter;
      default: base_ptr = gpr[base_mode[2:0]];
    endcase
    len_sum = {6'h00, indexed};
    if (one_disp || two_disp) begin
      len_sum = len_sum + {4'h0, d1_len};
    end
    if (two_disp) begin
      len_sum = len_sum + {4'h0, d2_len};
    end
  end

  wire [31:0] ptr_addr = m_ext ? (link_table_base + {d1_val[29:0], 2'h0})
                               : (base_ptr + d1_val);
  wire [31:0] direct_ea = m_abs ? d1_val :
                          m_tos ? cur_sp :
                          (base_ptr + d1_val);
  wire [63:0] ext_tail = ext_stream << {len_sum, 3'h0};

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    mem_req_d = mem_req_q;
    mem_addr_d = mem_addr_q;
    done_d = 1'h0;
    eff_addr_d = eff_addr_q;
    is_register_d = is_register_q;
    reg_num_d = reg_num_q;
    is_immediate_d = is_immediate_q;
    stack_push_d = stack_push_q;
    stack_pop_d = stack_pop_q;
    illegal_d = illegal_q;
    ext_len_d = ext_len_q;
    implied_imm_d = implied_imm_q;
    short_operand_d = short_operand_q;
    cond_code_d = cond_code_q;
    disp2_d = disp2_q;
    idx_add_d = idx_add_q;
    case (state_q)
      S_IDLE: begin
        if (dec_valid) begin
          is_register_d = m_reg && !indexed;
          reg_num_d = base_mode[2:0];
          is_immediate_d = m_imm;
          stack_push_d = m_tos && op_is_write;
          stack_pop_d = m_tos && !op_is_write;
          illegal_d = bad_any;
          ext_len_d = len_sum;
          implied_imm_d = ext_tail[63:56];
          short_operand_d = basic_bytes[`OAMD_SHORT_LSB +: 4];
          cond_code_d = basic_bytes[`OAMD_COND_LSB +: 4];
          disp2_d = d2_val;
          idx_add_d = indexed ? idx_scaled : 32'h00000000;
          // an illegal pointer mode finishes without touching memory
          if (two_disp && !bad_any) begin
            mem_req_d = 1'h1;
            mem_addr_d = ptr_addr;
            state_d = S_PTR;
          end else begin
            // a register operand used as an index base means its contents
            eff_addr_d = (m_reg ? gpr[base_mode[2:0]] : direct_ea) +
                         (indexed ? idx_scaled : 32'h00000000);
            state_d = S_DONE;
          end
        end
      end
      S_PTR: begin
        if (mem_ack) begin
          mem_req_d = 1'h0;
          // sums wrap silently, carries out are dropped
          eff_addr_d = mem_rdata + disp2_q + idx_add_q;
          state_d = S_DONE;
        end
      end
      S_DONE: begin
        done_d = 1'h1;
        state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      mem_req_q <= 1'h0;
      mem_addr_q <= 32'h00000000;
      done_q <= 1'h0;
      eff_addr_q <= 32'h00000000;
      is_register_q <= 1'h0;
      reg_num_q <= 3'h0;
      is_immediate_q <= 1'h0;
      stack_push_q <= 1'h0;
      stack_pop_q <= 1'h0;
      illegal_q <= 1'h0;
      ext_len_q <= 7'h00;
      implied_imm_q <= 8'h00;
      short_operand_q <= 4'h0;
      cond_code_q <= 4'h0;
      disp2_q <= 32'h00000000;
      idx_add_q <= 32'h00000000;
    end else begin
      state_q <= state_d;
      mem_req_q <= mem_req_d;
      mem_addr_q <= mem_addr_d;
      done_q <= done_d;
      eff_addr_q <= eff_addr_d;
      is_register_q <= is_register_d;
      reg_num_q <= reg_num_d;
      is_immediate_q <= is_immediate_d;
      stack_push_q <= stack_push_d;
      stack_pop_q <= stack_pop_d;
      illegal_q <= illegal_d;
      ext_len_q <= ext_len_d;
      implied_imm_q <= implied_imm_d;
      short_operand_q <= short_operand_d;
      cond_code_q <= cond_code_d;
      disp2_q <= disp2_d;
      idx_add_q <= idx_add_d;
    end
  end

  // ----------------------------------------
  // outputs, each straight from its flop
  // ----------------------------------------
  assign mem_req = mem_req_q;
  assign mem_addr = mem_addr_q;
  assign done = done_q;
  assign eff_addr = eff_addr_q;
  assign is_register = is_register_q;
  assign reg_num = reg_num_q;
  assign is_immediate = is_immediate_q;
  assign stack_push = stack_push_q;
  assign stack_pop = stack_pop_q;
  assign illegal = illegal_q;
  assign ext_len = ext_len_q;
  assign implied_imm = implied_imm_q;
  assign short_operand = short_operand_q;
  assign cond_code = cond_code_q;
endmodule // oamd_decoder

// File: oamd_regs.vh
// constants for the operand address mode decoder
`ifndef OAMD_REGS_VH
`define OAMD_REGS_VH
// ----------------------------------------
// mode field codes
// ----------------------------------------
`define OAMD_MODE_REG_HI 5'h07
`define OAMD_MODE_RREL_LO 5'h08
`define OAMD_MODE_RREL_HI 5'h0F
`define OAMD_MODE_MREL_FP 5'h10
`define OAMD_MODE_MREL_SP 5'h11
`define OAMD_MODE_MREL_SB 5'h12
`define OAMD_MODE_RSVD 5'h13
`define OAMD_MODE_IMM 5'h14
`define OAMD_MODE_ABS 5'h15
`define OAMD_MODE_EXT 5'h16
`define OAMD_MODE_TOS 5'h17
`define OAMD_MODE_MSP_FP 5'h18
`define OAMD_MODE_MSP_SP 5'h19
`define OAMD_MODE_MSP_SB 5'h1A
`define OAMD_MODE_MSP_PC 5'h1B
`define OAMD_MODE_IDX_LO 5'h1C
// ----------------------------------------
// displacement size prefixes
// ----------------------------------------
`define OAMD_DISP_RSVD 8'hE0
// ----------------------------------------
// field positions in basic instruction
// ----------------------------------------
`define OAMD_SHORT_LSB 7
`define OAMD_COND_LSB 4
`endif

// File: oamd_disp_extract.v
// displacement field size decode and sign extension
module oamd_disp_extract (
  input wire [31:0] ext_bytes,
  output reg [31:0] disp_value,
  output reg [2:0] disp_len,
  output reg disp_reserved
);
  // bytes arrive most significant first in ext_bytes[31:24]
  always @* begin
    disp_reserved = (ext_bytes[31:24] == `OAMD_DISP_RSVD);
    if (!ext_bytes[31]) begin
      disp_len = 3'h1;
      disp_value = {{25{ext_bytes[30]}}, ext_bytes[30:24]};
    end else if (!ext_bytes[30]) begin
      disp_len = 3'h2;
      disp_value = {{18{ext_bytes[29]}}, ext_bytes[29:16]};
    end else begin
      disp_len = 3'h4;
      disp_value = {{2{ext_bytes[29]}}, ext_bytes[29:0]};
    end
  end
endmodule // oamd_disp_extract

// File: oamd_props.sv
// assertions on the operand decoder ports
module oamd_props (
  input wire clk,
  input wire rst_b,
  input wire op_is_write,
  input wire [15:0] basic_bytes,
  input wire mem_ack,
  input wire mem_req,
  input wire [31:0] mem_addr,
  input wire done,
  input wire is_register,
  input wire is_immediate,
  input wire stack_push,
  input wire stack_pop,
  input wire illegal,
  input wire [3:0] short_operand,
  input wire [3:0] cond_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_wait; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
  a_wait: assert property (p_wait) else $error("pointer read dropped early");
  property p_ack; mem_req && mem_ack |=> !mem_req ##1 done; endproperty
  a_ack: assert property (p_ack) else $error("no finish after pointer");
  property p_pulse; done |=> !done; endproperty
  a_pulse: assert property (p_pulse) else $error("done held");
  property p_quiet; done |-> !mem_req; endproperty
  a_quiet: assert property (p_quiet) else $error("read open at done");
  property p_dir; done |-> !(stack_push && stack_pop); endproperty
  a_dir: assert property (p_dir) else $error("push and pop");
  property p_push; done && stack_push |-> op_is_write; endproperty
  a_push: assert property (p_push) else $error("push on read");
  property p_imm; done && is_immediate && op_is_write |-> illegal; endproperty
  a_imm: assert property (p_imm) else $error("immediate written");
  property p_reg; done && is_register |-> !is_immediate && !stack_push && !stack_pop; endproperty
  a_reg: assert property (p_reg) else $error("register mode mixed");
  property p_short; done |-> short_operand == basic_bytes[10:7]; endproperty
  a_short: assert property (p_short) else $error("short field");
  property p_cond; done |-> cond_code == basic_bytes[7:4]; endproperty
  a_cond: assert property (p_cond) else $error("cond field");
endmodule // oamd_props

// File: oamd_mem_model.sv
// pointer memory answering the decoder's reads
module oamd_mem_model (
  input wire clk,
  input wire rst_b,
  input wire slow,
  input wire mem_req,
  input wire [31:0] mem_addr,
  output reg mem_ack,
  output reg [31:0] mem_rdata
);
  reg [1:0] wait_q;
  // pointer is the inverted address; data churns while no read is requested so stale data never matches
  always @(posedge clk) begin
    mem_ack <= 1'h0;
    if (!rst_b) begin
      wait_q <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack) begin
      wait_q <= wait_q + 2'h1;
      if (wait_q == (slow ? 2'h3 : 2'h0)) begin
        mem_ack <= 1'h1;
        mem_rdata <= ~mem_addr;
        wait_q <= 2'h0;
      end
    end else if (!mem_ack) begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // oamd_mem_model

// File: operand_address_mode_decoder_tb.sv
// testbench for the operand address mode decoder
module operand_address_mode_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg clk = 1'h0, rst_b = 1'h0, dec_valid = 1'h0, op_is_write = 1'h0, stack_select = 1'h0;
  reg slow = 1'h0;
  reg [4:0] gen_mode = 5'h00;
  reg [7:0] index_byte = 8'h00;
  reg [15:0] basic_bytes = 16'h0590;
  reg [63:0] ext_stream = 64'h0;
  reg [255:0] gpr_flat = {32'h740, 32'h640, 32'h540, 32'h440,
                          32'h340, 32'hFFFFFFF0, 32'h140, 32'h40};
  reg [31:0] frame_pointer = 32'h2000, static_base_pointer = 32'h3000;
  reg [31:0] interrupt_stack_pointer = 32'h4000, user_stack_pointer = 32'h5000;
  reg [31:0] program_counter = 32'h7000, link_table_base = 32'h6000;
  wire mem_ack, mem_req, done, is_register, is_immediate, stack_push, stack_pop, illegal;
  wire [31:0] mem_rdata, mem_addr, eff_addr;
  wire [2:0] reg_num;
  wire [6:0] ext_len;
  wire [7:0] implied_imm;
  wire [3:0] short_operand, cond_code;
  integer error_cnt = 0, comparisons = 0;
  oamd_decoder oamd_decoder_inst (.*);
  oamd_mem_model oamd_mem_model_inst (.*);
  initial forever #2 clk = ~clk;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task complete_run;
    begin
      if (error_cnt == 0 && comparisons > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input string name, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("Error %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // inputs stay put until done, since results may be formed late
  task run(input [4:0] m, input [7:0] ib, input w, input [63:0] e);
    integer i;
    begin
      @(posedge clk);
      gen_mode <= m;
      index_byte <= ib;
      op_is_write <= w;
      ext_stream <= e;
      dec_valid <= 1'h1;
      @(posedge clk);
      dec_valid <= 1'h0;
      for (i = 0; i < 40 && done !== 1'h1; i = i + 1)
        @(posedge clk);
      if (done !== 1'h1) begin
        error_cnt = error_cnt + 1;
        complete_run;
      end
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reg;
    begin
      run(5'h03, 8'h00, 1'h1, 64'h0);
      chk("is_register", is_register, 32'h1);
      chk("reg_num", reg_num, 32'h3);
      chk("short_operand", short_operand, 32'hB);
      chk("cond_code", cond_code, 32'h9);
      basic_bytes <= 16'h02D0;
      run(5'h06, 8'h00, 1'h0, 64'h0);
      chk("reg_num", reg_num, 32'h6);
      chk("short_operand", short_operand, 32'h5);
      chk("cond_code", cond_code, 32'hD);
    end
  endtask
  task t_rel;
    begin
      run(5'h0A, 8'h00, 1'h0, 64'h3F00_0000_0000_0000);
      chk("eff_addr", eff_addr, 32'h2F);
      chk("ext_len", ext_len, 32'h1);
      run(5'h09, 8'h00, 1'h0, 64'h7F00_0000_0000_0000);
      chk("eff_addr", eff_addr, 32'h13F);
    end
  endtask
  task t_abs;
    begin
      run(5'h15, 8'h00, 1'h0, 64'h8123_0000_0000_0000);
      chk("eff_addr", eff_addr, 32'h123);
      chk("ext_len", ext_len, 32'h2);
      run(5'h15, 8'h00, 1'h0, 64'hE100_0000_0000_0000);
      chk("eff_addr", eff_addr, 32'hE1000000);
      chk("ext_len", ext_len, 32'h4);
      run(5'h15, 8'h00, 1'h0, 64'hE000_0000_0000_0000);
      chk("illegal", illegal, 32'h1);
    end
  endtask
  task t_mem;
    begin
      slow <= 1'h1;
      run(5'h10, 8'h00, 1'h0, 64'h0408_0000_0000_0000);
      chk("eff_addr", eff_addr, 32'hFFFFE003);
      slow <= 1'h0;
      stack_select <= 1'h1;
      run(5'h11, 8'h00, 1'h0, 64'h0408_0000_0000_0000);
      chk("eff_addr", eff_addr, 32'hFFFFB003);
      run(5'h16, 8'h00, 1'h0, 64'h0205_0000_0000_0000);
      chk("eff_addr", eff_addr, 32'hFFFF9FFC);
      run(5'h12, 8'h00, 1'h0, 64'h0102_0000_0000_0000);
      chk("eff_addr", eff_addr, 32'hFFFFD000);
      run(5'h1A, 8'h00, 1'h0, 64'hBFFF_0000_0000_0000);
      chk("eff_addr", eff_addr, 32'h2FFF);
      run(5'h1B, 8'h00, 1'h0, 64'hC000_0010_0000_0000);
      chk("eff_addr", eff_addr, 32'h7010);
      chk("ext_len", ext_len, 32'h4);
      run(5'h13, 8'h00, 1'h0, 64'h0);
      chk("illegal", illegal, 32'h1);
    end
  endtask
  task t_stack_imm;
    begin
      stack_select <= 1'h1;
      run(5'h17, 8'h00, 1'h1, 64'h0);
      chk("stack_push", stack_push, 32'h1);
      chk("eff_addr", eff_addr, 32'h5000);
      stack_select <= 1'h0;
      run(5'h17, 8'h00, 1'h0, 64'h0);
      chk("stack_pop", stack_pop, 32'h1);
      chk("eff_addr", eff_addr, 32'h4000);
      run(5'h14, 8'h00, 1'h1, 64'h0);
      chk("illegal", illegal, 32'h1);
      run(5'h14, 8'h00, 1'h0, 64'h0);
      chk("is_immediate", is_immediate, 32'h1);
      chk("illegal", illegal, 32'h0);
    end
  endtask
  task t_idx;
    begin
      run(5'h1C, 8'hA9, 1'h0, 64'hA910_9C00_0000_0000);
      chk("eff_addr", eff_addr, 32'h150);
      chk("ext_len", ext_len, 32'h2);
      chk("implied_imm", implied_imm, 32'h9C);
      run(5'h1F, 8'hA9, 1'h0, 64'hA910_9C00_0000_0000);
      chk("eff_addr", eff_addr, 32'hA10);
      run(5'h1E, 8'hA1, 1'h0, 64'hA100_0000_0000_0000);
      chk("illegal", illegal, 32'h1);
    end
  endtask
  // reset lands while a slow pointer read is still pending
  task t_reset;
    begin
      slow <= 1'h1;
      @(posedge clk);
      gen_mode <= 5'h10;
      index_byte <= 8'h00;
      op_is_write <= 1'h0;
      ext_stream <= 64'h0408_0000_0000_0000;
      dec_valid <= 1'h1;
      @(posedge clk);
      dec_valid <= 1'h0;
      @(posedge clk);
      rst_b <= 1'h0;
      repeat (2) @(posedge clk);
      rst_b <= 1'h1;
      chk("mem_req", mem_req, 32'h0);
      chk("eff_addr", eff_addr, 32'h0);
      slow <= 1'h0;
      run(5'h10, 8'h00, 1'h0, 64'h0408_0000_0000_0000);
      chk("eff_addr", eff_addr, 32'hFFFFE003);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    t_reg;
    t_rel;
    t_abs;
    t_mem;
    t_stack_imm;
    t_idx;
    t_reset;
    complete_run;
  end
endmodule // operand_address_mode_decoder_tb
bind oamd_decoder oamd_props oamd_props_inst (.*);
